// File: common/drive_regs.svh
// Object indices, field positions, reset values and timing of the decoder
// What this block does
// - Bits 0,1,2,3,7 drive the state machine
// - Shutdown, switch on, enable operation decoded
// - Disable voltage and quick stop decoded
// - Bit 8 set halts the commanded motion
// - Bit 11 set clears warning flag
// - Bits 4,5,6,9 go to mode logic
// - Fault reset ignored; fault state kept
// - Switch on with bit 3 stops switched on
// - Last alarm error code read only
// - Modes mask reports bits 2,3,16,17
// - Nameplate string, empty until assigned
// - Maker string, empty until assigned
// - Bits 10 and 12..15 ignored
// - Warning flag set by any warning
`ifndef DRIVE_REGS_SVH
`define DRIVE_REGS_SVH

// Object indices
`define IDX_CMD_WORD       16'h6040
`define IDX_LAST_ERROR     16'h603f
`define IDX_MODES_MASK     16'h6502
`define IDX_NAMEPLATE      16'h6403
`define IDX_MAKER          16'h6404

// Command word field positions
`define CW_SWITCH_ON       0
`define CW_ENABLE_VOLTAGE  1
`define CW_QUICK_STOP      2
`define CW_ENABLE_OP       3
`define CW_MODE_A          4
`define CW_MODE_B          5
`define CW_MODE_C          6
`define CW_FAULT_RESET     7
`define CW_HALT            8
`define CW_MODE_D          9
`define CW_WARN_ACK        11

// Reset values
`define CMD_WORD_RESET     16'h0000
`define LAST_ERROR_RESET   16'h0000
`define STRING_RESET       32'h00000000
`define MODES_MASK_VALUE   32'h0003000c

// Timing
`define SETTLE_TIME_MS     40
`define MCLK_FREQ_KHZ      200000

`endif

// File: common/drive_pkg.sv
// Types shared by the command word decoder and its classifier
package drive_pkg;

  typedef enum logic [2:0] {
    ST_SWITCH_ON_DISABLED,
    ST_READY_TO_SWITCH_ON,
    ST_SWITCHED_ON,
    ST_OPERATION_ENABLED,
    ST_QUICK_STOP_ACTIVE,
    ST_FAULT
  } drive_state_t;

  typedef enum logic [2:0] {
    CMD_SHUTDOWN,
    CMD_SWITCH_ON,
    CMD_ENABLE_OPERATION,
    CMD_DISABLE_VOLTAGE,
    CMD_QUICK_STOP,
    CMD_FAULT_RESET
  } drive_cmd_t;

  typedef struct packed {
    logic [4:0]   trans_id;
    logic         moved;
    drive_state_t state;
  } step_t;

  typedef struct packed {
    logic [15:0]  cmd_word;
    logic         cmd_pending;
    drive_state_t state;
    logic         warning;
    logic         halt;
    logic [3:0]   mode_bits;
    logic [15:0]  last_error;
    logic [31:0]  nameplate;
    logic [31:0]  maker;
    logic [31:0]  rdata;
    logic         ack;
    logic         err;
    logic         trans_strobe;
    logic [4:0]   trans_id;
    logic         cmd_ignored;
    logic         reset_refused;
    logic         cmd_early;
    logic [31:0]  settle_cnt;
    logic         settling;
  } decoder_state_t;

endpackage

// File: verilog/drive_command_classifier.sv
// Classifies a command word into one state machine command
`timescale 1ns/1ps
`default_nettype none
`include "drive_regs.svh"

module drive_command_classifier (
  // Command word as written by the master
  input  wire logic [15:0]       cmd_word,
  // Decoded command
  output drive_pkg::drive_cmd_t  cmd
);

  // Priority order makes every pattern map to exactly one command;
  // bits 4..6 and 8..15 never reach this decision.
  always_comb begin
    if (cmd_word[`CW_FAULT_RESET]) begin
      cmd = drive_pkg::CMD_FAULT_RESET;
    end else if (!cmd_word[`CW_ENABLE_VOLTAGE]) begin
      cmd = drive_pkg::CMD_DISABLE_VOLTAGE;
    end else if (!cmd_word[`CW_QUICK_STOP]) begin
      cmd = drive_pkg::CMD_QUICK_STOP;
    end else if (!cmd_word[`CW_SWITCH_ON]) begin
      cmd = drive_pkg::CMD_SHUTDOWN;
    end else if (cmd_word[`CW_ENABLE_OP]) begin
      cmd = drive_pkg::CMD_ENABLE_OPERATION;
    end else begin
      cmd = drive_pkg::CMD_SWITCH_ON;
    end
  end

endmodule

`default_nettype wire

// File: verilog/drive_command_word_decoder.sv
// Command word decoder, drive state machine and identification objects
`timescale 1ns/1ps
`default_nettype none
`include "drive_regs.svh"

module drive_command_word_decoder #(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_TIME_MS * `MCLK_FREQ_KHZ
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Object access from the fieldbus stack
  input  wire logic                  obj_wr_en,
  input  wire logic                  obj_rd_en,
  input  wire logic [15:0]           obj_index,
  input  wire logic [31:0]           obj_wdata,
  output logic [31:0]                obj_rdata,
  output logic                       obj_ack,
  output logic                       obj_err,
  // Drive events
  input  wire logic                  alarm_event,
  input  wire logic [15:0]           alarm_code,
  input  wire logic                  warning_event,
  // Drive state and mode outputs
  output drive_pkg::drive_state_t    drive_state,
  output logic                       warning_flag,
  output logic                       halt_motion,
  output logic [3:0]                 mode_bits,
  // Transition events
  output logic                       trans_strobe,
  output logic [4:0]                 trans_id,
  output logic                       cmd_ignored,
  output logic                       fault_reset_refused,
  output logic                       cmd_early,
  output logic                       settling
);

  generate
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("SETTLE_CYCLES must be at least one");
    end
  endgenerate

  // Wide enough for the full settling window at the default clock
  localparam logic [31:0] SETTLE_LOAD = 32'(SETTLE_CYCLES);

  drive_pkg::decoder_state_t s;
  drive_pkg::decoder_state_t n;
  drive_pkg::drive_cmd_t     cmd;

  // Classifier reads the registered word, so decode lags the write a cycle
  drive_command_classifier u_classifier (
    .cmd_word (s.cmd_word),
    .cmd      (cmd)
  );

  // Builds one step result
  function automatic drive_pkg::step_t go(
    input drive_pkg::drive_state_t st,
    input logic [4:0]              tid
  );
    drive_pkg::step_t r;
    r.state = st;
    r.trans_id = tid;
    r.moved = 1'b1;
    return r;
  endfunction

  // Transition table; anything not listed keeps the state
  function automatic drive_pkg::step_t step(
    input drive_pkg::drive_state_t st,
    input drive_pkg::drive_cmd_t   c
  );
    drive_pkg::step_t r;
    r.state = st;
    r.trans_id = 5'h00;
    r.moved = 1'b0;

    unique case (st)
      drive_pkg::ST_SWITCH_ON_DISABLED: begin
        if (c == drive_pkg::CMD_SHUTDOWN) begin
          r = go(drive_pkg::ST_READY_TO_SWITCH_ON, 5'h02);
        end
      end

      drive_pkg::ST_READY_TO_SWITCH_ON: begin
        // Enable operation here only switches on; no automatic run
        if (c == drive_pkg::CMD_SWITCH_ON ||
            c == drive_pkg::CMD_ENABLE_OPERATION) begin
          r = go(drive_pkg::ST_SWITCHED_ON, 5'h03);
        end else if (c == drive_pkg::CMD_DISABLE_VOLTAGE ||
                     c == drive_pkg::CMD_QUICK_STOP) begin
          r = go(drive_pkg::ST_SWITCH_ON_DISABLED, 5'h07);
        end
      end

      drive_pkg::ST_SWITCHED_ON: begin
        if (c == drive_pkg::CMD_ENABLE_OPERATION) begin
          r = go(drive_pkg::ST_OPERATION_ENABLED, 5'h04);
        end else if (c == drive_pkg::CMD_SHUTDOWN) begin
          r = go(drive_pkg::ST_READY_TO_SWITCH_ON, 5'h06);
        end else if (c == drive_pkg::CMD_DISABLE_VOLTAGE ||
                     c == drive_pkg::CMD_QUICK_STOP) begin
          r = go(drive_pkg::ST_SWITCH_ON_DISABLED, 5'h0a);
        end
      end

      drive_pkg::ST_OPERATION_ENABLED: begin
        if (c == drive_pkg::CMD_SWITCH_ON) begin
          r = go(drive_pkg::ST_SWITCHED_ON, 5'h05);
        end else if (c == drive_pkg::CMD_SHUTDOWN) begin
          r = go(drive_pkg::ST_READY_TO_SWITCH_ON, 5'h08);
        end else if (c == drive_pkg::CMD_DISABLE_VOLTAGE) begin
          r = go(drive_pkg::ST_SWITCH_ON_DISABLED, 5'h09);
        end else if (c == drive_pkg::CMD_QUICK_STOP) begin
          r = go(drive_pkg::ST_QUICK_STOP_ACTIVE, 5'h0b);
        end
      end

      drive_pkg::ST_QUICK_STOP_ACTIVE: begin
        if (c == drive_pkg::CMD_ENABLE_OPERATION) begin
          r = go(drive_pkg::ST_OPERATION_ENABLED, 5'h10);
        end else if (c == drive_pkg::CMD_DISABLE_VOLTAGE) begin
          r = go(drive_pkg::ST_SWITCH_ON_DISABLED, 5'h0c);
        end
      end

      drive_pkg::ST_FAULT: begin
        // No way out of fault short of a device reset
        r.moved = 1'b0;
      end
    endcase
    return r;
  endfunction

  // True for indices that answer at all
  function automatic logic known_index(input logic [15:0] idx);
    return idx == `IDX_CMD_WORD   || idx == `IDX_LAST_ERROR ||
           idx == `IDX_MODES_MASK || idx == `IDX_NAMEPLATE  ||
           idx == `IDX_MAKER;
  endfunction

  // True for indices the master may write
  function automatic logic writable_index(input logic [15:0] idx);
    return idx == `IDX_CMD_WORD || idx == `IDX_NAMEPLATE ||
           idx == `IDX_MAKER;
  endfunction

  // Read value of one object; unknown indices read zero
  function automatic logic [31:0] read_object(
    input logic [15:0]               idx,
    input drive_pkg::decoder_state_t st
  );
    logic [31:0] v;
    v = 32'h00000000;
    unique case (idx)
      `IDX_CMD_WORD:   v = {16'h0000, st.cmd_word};
      `IDX_LAST_ERROR: v = {16'h0000, st.last_error};
      `IDX_MODES_MASK: v = `MODES_MASK_VALUE;
      `IDX_NAMEPLATE:  v = st.nameplate;
      `IDX_MAKER:      v = st.maker;
      default:         v = 32'h00000000;
    endcase
    return v;
  endfunction

  // Mode-specific bits in the order the mode logic expects
  function automatic logic [3:0] mode_field(input logic [15:0] w);
    return {w[`CW_MODE_D], w[`CW_MODE_C], w[`CW_MODE_B], w[`CW_MODE_A]};
  endfunction

  always_comb begin
    drive_pkg::step_t stp;
    logic             cmd_write;
    logic             warn_ack;

    // The step is worked out every cycle but applied only on a decode
    stp = step(s.state, cmd);
    cmd_write = 1'b0;
    warn_ack = 1'b0;

    // Strobes fall back low every cycle; levels hold by default
    n = s;
    n.ack = 1'b0;
    n.err = 1'b0;
    // Read data rests at zero so a stale value never looks like an answer
    n.rdata = 32'h00000000;
    n.trans_strobe = 1'b0;
    n.trans_id = 5'h00;
    n.cmd_ignored = 1'b0;
    n.reset_refused = 1'b0;
    n.cmd_early = 1'b0;

    // Object access: write wins when both strobes are high
    if (obj_wr_en) begin
      n.ack = 1'b1;
      // Read-only and unknown objects are refused and keep their value
      if (!writable_index(obj_index)) begin
        n.err = 1'b1;
      end else if (obj_index == `IDX_CMD_WORD) begin
        n.cmd_word = obj_wdata[15:0];
        cmd_write = 1'b1;
      end else if (obj_index == `IDX_NAMEPLATE) begin
        n.nameplate = obj_wdata;
      end else begin
        n.maker = obj_wdata;
      end
    end else if (obj_rd_en) begin
      n.ack = 1'b1;
      n.err = !known_index(obj_index);
      n.rdata = read_object(obj_index, s);
    end

    // A command word write arms one decode in the following cycle
    n.cmd_pending = cmd_write;

    if (s.cmd_pending) begin
      warn_ack = s.cmd_word[`CW_WARN_ACK];
      n.halt = s.cmd_word[`CW_HALT];
      n.mode_bits = mode_field(s.cmd_word);
      n.cmd_early = s.settling;
      if (cmd == drive_pkg::CMD_FAULT_RESET) begin
        n.reset_refused = 1'b1;
      end else if (stp.moved) begin
        n.state = stp.state;
        n.trans_strobe = 1'b1;
        n.trans_id = stp.trans_id;
      end else begin
        n.cmd_ignored = 1'b1;
      end
    end

    // Alarm overrides any command decoded in the same cycle
    if (alarm_event) begin
      n.state = drive_pkg::ST_FAULT;
      n.last_error = alarm_code;
      n.trans_strobe = 1'b0;
      n.trans_id = 5'h00;
    end

    // Settling window after each transition; early commands still act.
    // Placed after the alarm so a suppressed transition opens no window.
    if (n.trans_strobe) begin
      n.settle_cnt = SETTLE_LOAD;
    end else if (s.settle_cnt != 32'h00000000) begin
      // Runs down to zero and stops there
      n.settle_cnt = s.settle_cnt - 32'h00000001;
    end
    n.settling = (n.settle_cnt != 32'h00000000);

    // New warning wins over an acknowledge in the same cycle
    n.warning = (s.warning & ~warn_ack) | warning_event;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s.cmd_word <= `CMD_WORD_RESET;
      s.cmd_pending <= 1'b0;
      s.state <= drive_pkg::ST_SWITCH_ON_DISABLED;
      s.warning <= 1'b0;
      s.halt <= 1'b0;
      s.mode_bits <= 4'h0;
      s.last_error <= `LAST_ERROR_RESET;
      // Strings start empty until the master assigns them
      s.nameplate <= `STRING_RESET;
      s.maker <= `STRING_RESET;
      s.rdata <= 32'h00000000;
      s.ack <= 1'b0;
      s.err <= 1'b0;
      s.trans_strobe <= 1'b0;
      s.trans_id <= 5'h00;
      s.cmd_ignored <= 1'b0;
      s.reset_refused <= 1'b0;
      s.cmd_early <= 1'b0;
      s.settle_cnt <= 32'h00000000;
      s.settling <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // Object answers
  assign obj_rdata = s.rdata;
  assign obj_ack = s.ack;
  assign obj_err = s.err;

  // Drive levels
  assign drive_state = s.state;
  assign warning_flag = s.warning;
  assign halt_motion = s.halt;
  assign mode_bits = s.mode_bits;

  // Transition events
  assign trans_strobe = s.trans_strobe;
  assign trans_id = s.trans_id;
  assign cmd_ignored = s.cmd_ignored;
  assign fault_reset_refused = s.reset_refused;
  assign cmd_early = s.cmd_early;
  assign settling = s.settling;

endmodule

`default_nettype wire

// File: bench/drive_master_model.sv
// Fieldbus master model issuing object reads and writes to the decoder
`timescale 1ns/1ps
`default_nettype none
module drive_master_model #(
  parameter int SETTLE = 8
) (
  // Clock
  input  wire logic        mclk,
  // Object access
  output logic             obj_wr_en,
  output logic             obj_rd_en,
  output logic [15:0]      obj_index,
  output logic [31:0]      obj_wdata,
  input  wire logic [31:0] obj_rdata,
  input  wire logic        obj_ack,
  input  wire logic        obj_err
);
  initial begin
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h00000000;
  end
  // One-cycle request; a missing answer returns an unknown error flag
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge mclk);
    #1;
    obj_wr_en = w;
    obj_rd_en = !w;
    obj_index = i;
    obj_wdata = d;
    @(posedge mclk);
    #1;
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    // Released lines show inverted data so stale values never match
    obj_index = ~i;
    obj_wdata = ~d;
    q = obj_rdata;
    e = obj_ack ? obj_err : 1'bx;
  endtask
  // Gap between state commands
  task automatic settle();
    repeat (SETTLE + 2) @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// File: bench/drive_command_word_decoder_asserts.sv
// Concurrent checks on the command word decoder ports
`timescale 1ns/1ps
`default_nettype none
module drive_command_word_decoder_asserts (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // Object access
  input wire logic                    obj_wr_en,
  input wire logic                    obj_rd_en,
  input wire logic [15:0]             obj_index,
  input wire logic [31:0]             obj_wdata,
  input wire logic [31:0]             obj_rdata,
  input wire logic                    obj_err,
  // Events and state
  input wire logic                    alarm_event,
  input wire logic                    warning_event,
  input wire drive_pkg::drive_state_t drive_state,
  input wire logic                    warning_flag,
  input wire logic                    halt_motion,
  input wire logic [3:0]              mode_bits
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic cw_wr;
  assign cw_wr = obj_wr_en && obj_index == 16'h6040;

  mode_read_a: assert property (obj_rd_en && !obj_wr_en
    && obj_index == 16'h6502 |=> obj_rdata == 32'h0003000c && !obj_err)
    else $error("modes mask read wrong");
  ro_write_a: assert property (obj_wr_en && obj_index == 16'h603f
    |=> obj_err) else $error("read-only write accepted");
  halt_follow_a: assert property (cw_wr |=> ##1
    halt_motion == $past(obj_wdata[8], 2)) else $error("halt not taken");
  mode_follow_a: assert property (cw_wr |=> ##1 mode_bits ==
    {$past(obj_wdata[9], 2), $past(obj_wdata[6:4], 2)})
    else $error("mode bits lost");
  fault_hold_a: assert property (drive_state == drive_pkg::ST_FAULT
    |=> drive_state == drive_pkg::ST_FAULT) else $error("fault state left");
  warn_set_a: assert property (warning_event |=> warning_flag)
    else $error("warning not flagged");
  warn_ack_a: assert property (cw_wr && obj_wdata[11] ##1 !warning_event
    |=> !warning_flag) else $error("warning not cleared");
  no_auto_run_a: assert property (cw_wr && obj_wdata[3:0] == 4'hf
    && !obj_wdata[7] ##1 drive_state == drive_pkg::ST_READY_TO_SWITCH_ON
    && !alarm_event |=> drive_state == drive_pkg::ST_SWITCHED_ON)
    else $error("switch on ran past switched on");
endmodule
`default_nettype wire

// File: bench/drive_command_word_decoder_bench.sv
// Self-checking bench for the command word decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); \
  end \
end
module drive_command_word_decoder_bench;
  localparam int SETTLE = 8;
  logic                    mclk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    alarm_event = 1'b0;
  logic                    warning_event = 1'b0;
  logic [15:0]             alarm_code = 16'h0000;
  logic                    obj_wr_en, obj_rd_en, obj_ack, obj_err, e;
  logic [15:0]             obj_index;
  logic [31:0]             obj_wdata, obj_rdata, q;
  logic [4:0]              trans_id;
  logic [3:0]              mode_bits;
  logic                    warning_flag, halt_motion, trans_strobe;
  logic                    cmd_ignored, fault_reset_refused;
  logic                    cmd_early, settling;
  drive_pkg::drive_state_t drive_state;
  int                      num_errors = 0;
  int                      samples_checked = 0;
  // Row: command word, expected state, expected transition (0 = none)
  logic [27:0] rows [28] = '{
    28'h000f000, 28'h0006102, 28'hfc0f203, 28'h000f304,
    28'h0007205, 28'h000f304, 28'h0006108, 28'h0007203,
    28'h0006106, 28'h0007203, 28'h000000a, 28'h0006102,
    28'h0002007, 28'h0006102, 28'h0007203, 28'h000b00a,
    28'h0006102, 28'h0007203, 28'h007f304, 28'h000240b,
    28'h000f310, 28'h000240b, 28'h000000c, 28'h0006102,
    28'h0007203, 28'h030f304, 28'h0000009, 28'h0080000};

  drive_master_model #(.SETTLE(SETTLE)) m (.*);
  drive_command_word_decoder #(.SETTLE_CYCLES(SETTLE)) dut (.*);

  always #2.5 mclk = ~mclk;

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic [27:0] r);
    m.xfer(1'b1, 16'h6040, {16'h0000, r[27:12]}, q, e);
    `CHK(e, 1'b0)
    @(posedge mclk);
    #1;
    `CHK(drive_state, r[10:8])
    `CHK(trans_id, r[4:0])
    `CHK(trans_strobe, r[4:0] != 5'h00)
    `CHK(halt_motion, r[20])
    `CHK(mode_bits, {r[21], r[18:16]})
    `CHK(cmd_ignored, r[4:0] == 5'h00 && !r[19])
    `CHK(fault_reset_refused, r[19])
    `CHK(settling, r[4:0] != 5'h00)
    `CHK(cmd_early, 1'b0)
    m.settle();
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    m.xfer(1'b0, 16'h6403, 32'h00000000, q, e);
    `CHK(q, 32'h00000000)
    m.xfer(1'b0, 16'h6404, 32'h00000000, q, e);
    `CHK(q, 32'h00000000)
    m.xfer(1'b0, 16'h6502, 32'h00000000, q, e);
    `CHK(q, 32'h0003000c)
    m.xfer(1'b1, 16'h6502, 32'h00000000, q, e);
    `CHK(e, 1'b1)
    m.xfer(1'b1, 16'h6403, 32'h00004331, q, e);
    m.xfer(1'b1, 16'h6404, 32'h004e614e, q, e);
    m.xfer(1'b0, 16'h6403, 32'h00000000, q, e);
    `CHK(q, 32'h00004331)
    m.xfer(1'b0, 16'h6404, 32'h00000000, q, e);
    `CHK(q, 32'h004e614e)
    foreach (rows[i]) run_cmd(rows[i]);
    warning_event = 1'b1;
    @(posedge mclk);
    #1;
    warning_event = 1'b0;
    `CHK(warning_flag, 1'b1)
    m.xfer(1'b1, 16'h6040, 32'h00000800, q, e);
    @(posedge mclk);
    #1;
    `CHK(warning_flag, 1'b0)
    m.settle();
    alarm_code = 16'h5a3c;
    alarm_event = 1'b1;
    @(posedge mclk);
    #1;
    alarm_event = 1'b0;
    `CHK(drive_state, drive_pkg::ST_FAULT)
    m.xfer(1'b0, 16'h603f, 32'h00000000, q, e);
    `CHK(q, 32'h00005a3c)
    m.xfer(1'b1, 16'h603f, 32'h00000000, q, e);
    `CHK(e, 1'b1)
    m.xfer(1'b1, 16'h6040, 32'h00000080, q, e);
    @(posedge mclk);
    #1;
    `CHK(fault_reset_refused, 1'b1)
    `CHK(drive_state, drive_pkg::ST_FAULT)
    m.settle();
    // Only a reset leaves the fault state
    rst_n = 1'b0;
    #1;
    `CHK(drive_state, drive_pkg::ST_SWITCH_ON_DISABLED)
    @(posedge mclk);
    #1;
    rst_n = 1'b1;
    run_cmd(28'h0006102);
    // Back-to-back words both act; the second one is flagged early
    m.xfer(1'b1, 16'h6040, 32'h00000007, q, e);
    m.xfer(1'b1, 16'h6040, 32'h0000f406, q, e);
    `CHK(e, 1'b0)
    @(posedge mclk);
    #1;
    `CHK(cmd_early, 1'b1)
    `CHK(drive_state, drive_pkg::ST_READY_TO_SWITCH_ON)
    `CHK(trans_id, 5'h06)
    @(posedge mclk);
    #1;
    `CHK(trans_strobe, 1'b0)
    m.xfer(1'b0, 16'h6040, 32'h00000000, q, e);
    `CHK(q, 32'h0000f406)
    m.xfer(1'b0, 16'h1234, 32'h00000000, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 32'h00000000)
    end_of_test();
  end

  initial begin
    repeat (2000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end
endmodule
bind drive_command_word_decoder drive_command_word_decoder_asserts chk (.*);
`default_nettype wire
